/* design/mas_menu.sv */
// Front-panel settings menu with advanced level, process value path and APB registers.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
module mas_menu #(
   parameter int unsigned ENTER_CYCLES = mas_pkg::ENTER_CYCLES,
   parameter int unsigned BACK_CYCLES  = mas_pkg::BACK_CYCLES
) (
   // Clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Front-panel keys and event input
   input  wire mas_pkg::mas_keys_t           keys,
   input  wire logic                         event_in,
   // Measurements
   input  wire logic                         meas_valid,
   input  wire logic signed [mas_pkg::MEAS_W-1:0] meas_value,
   // Display
   output logic [3:0]                        level_code,
   output logic [2:0]                        param_index,
   output logic                              value_shown,
   output logic                              value_blink,
   output logic signed [15:0]                display_value,
   output logic [1:0]                        display_dp,
   // Settings and process value
   output mas_pkg::mas_settings_t            settings,
   output logic [13:0]                       hys_one_eff,
   output logic [13:0]                       hys_two_eff,
   output logic                              pv_valid,
   output logic signed [mas_pkg::MEAS_W-1:0] pv_value
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   mas_pkg::mas_level_t    level, next_level;
   mas_pkg::mas_phase_t    phase, next_phase;
   mas_pkg::mas_settings_t next_settings;
   logic [2:0]             next_param;
   logic signed [15:0]     edit_val, next_edit_val;
   logic [mas_pkg::HOLD_W-1:0] hold_cnt, next_hold_cnt;
   logic                   hold_done, next_hold_done;
   mas_pkg::mas_keys_t     keys_q;
   logic [mas_pkg::CTRL_W-1:0] ctrl, next_ctrl;
   logic                   clear_all;
   logic                   event_ok;
   logic                   mode_rise, mode_fall, shift_rise, up_rise;
   logic signed [15:0]     cur_max, cur_min, stored_val;
   logic [2:0]             adv_next;

   assign mode_rise  = keys.mode & ~keys_q.mode;
   assign mode_fall  = ~keys.mode & keys_q.mode;
   assign shift_rise = keys.shift & ~keys_q.shift;
   assign up_rise    = keys.up & ~keys_q.up;
   assign event_ok   = (ctrl[1:0] == mas_pkg::IN_ANALOG) ||
                       (ctrl[1:0] == mas_pkg::IN_REMOTE);

   // ----------------------------------------------------------------
   // Parameter ranges and stored values
   // ----------------------------------------------------------------
   // Range and present value of the parameter under the cursor.
   always_comb begin
      cur_min    = 16'sd0;
      cur_max    = mas_pkg::FLAG_MAX;
      stored_val = 16'sd0;
      if (level == mas_pkg::LVL_INIT) begin
         cur_min = mas_pkg::PASS_MIN;
         cur_max = mas_pkg::HYS_MAX;
      end else begin
         case (param_index)
            mas_pkg::P_AVG: begin
               cur_max    = mas_pkg::AVG_MAX;
               stored_val = 16'(settings.averaging_count);
            end
            mas_pkg::P_EVENT: begin
               stored_val = 16'(settings.event_zero);
            end
            mas_pkg::P_HYSTERESIS_OUT_ONE: begin
               cur_max    = mas_pkg::HYS_MAX;
               stored_val = 16'(settings.hysteresis_out_one);
            end
            mas_pkg::P_HYSTERESIS_OUT_TWO: begin
               cur_max    = mas_pkg::HYS_MAX;
               stored_val = 16'(settings.hysteresis_out_two);
            end
            default: begin
               stored_val = 16'sd0;
            end
         endcase
      end
   end

   // Parameter after the current one; event is skipped for pulse inputs.
   always_comb begin
      case (param_index)
         mas_pkg::P_CLEAR: adv_next = mas_pkg::P_AVG;
         mas_pkg::P_AVG:   adv_next = event_ok ? mas_pkg::P_EVENT : mas_pkg::P_HYSTERESIS_OUT_ONE;
         mas_pkg::P_EVENT: adv_next = mas_pkg::P_HYSTERESIS_OUT_ONE;
         mas_pkg::P_HYSTERESIS_OUT_ONE:  adv_next = mas_pkg::P_HYSTERESIS_OUT_TWO;
         default:          adv_next = mas_pkg::P_CLEAR;
      endcase
   end

   // ----------------------------------------------------------------
   // Key sequencer
   // ----------------------------------------------------------------
   // Mode key: a hold fires once when its time is reached; a short press is
   // acted on at release, so a long hold never also advances the cursor.
   always_comb begin
      next_level     = level;
      next_phase     = phase;
      next_param     = param_index;
      next_edit_val  = edit_val;
      next_settings  = settings;
      next_hold_cnt  = hold_cnt;
      next_hold_done = hold_done;
      clear_all      = 1'b0;
      if (mode_rise) begin
         next_hold_cnt  = '0;
         next_hold_done = 1'b0;
      end else if (keys.mode && !hold_done) begin
         next_hold_cnt = mas_pkg::HOLD_W'(hold_cnt + 1'b1);
         if (level == mas_pkg::LVL_OP &&
             hold_cnt == mas_pkg::HOLD_W'(ENTER_CYCLES - 1)) begin
            next_level     = mas_pkg::LVL_INIT;
            next_phase     = mas_pkg::PH_NAME;
            next_param     = mas_pkg::P_CLEAR;
            next_hold_done = 1'b1;
         end else if (level != mas_pkg::LVL_OP &&
                      hold_cnt == mas_pkg::HOLD_W'(BACK_CYCLES - 1)) begin
            next_level     = (level == mas_pkg::LVL_ADV) ? mas_pkg::LVL_INIT
                                                         : mas_pkg::LVL_OP;
            next_phase     = mas_pkg::PH_NAME;
            next_param     = mas_pkg::P_CLEAR;
            next_hold_done = 1'b1;
         end
      end else if (mode_fall && !hold_done && level != mas_pkg::LVL_OP) begin
         next_phase = mas_pkg::PH_NAME;
         if (level == mas_pkg::LVL_INIT) begin
            if (phase == mas_pkg::PH_EDIT && edit_val == mas_pkg::PASSWORD) begin
               next_level = mas_pkg::LVL_ADV;
               next_param = mas_pkg::P_CLEAR;
            end
         end else begin
            next_param = adv_next;
            if (phase == mas_pkg::PH_EDIT) begin
               case (param_index)
                  mas_pkg::P_AVG:   next_settings.averaging_count = edit_val[1:0];
                  mas_pkg::P_EVENT: next_settings.event_zero      = edit_val[0];
                  mas_pkg::P_HYSTERESIS_OUT_ONE:  next_settings.hysteresis_out_one = edit_val[13:0];
                  mas_pkg::P_HYSTERESIS_OUT_TWO:  next_settings.hysteresis_out_two = edit_val[13:0];
                  default: begin
                     if (edit_val[0]) begin
                        clear_all     = 1'b1;
                        next_settings = '{mas_pkg::AVG_DEFAULT, 1'b0,
                                          mas_pkg::HYS_DEFAULT, mas_pkg::HYS_DEFAULT};
                     end
                  end
               endcase
            end
         end
      end else if (shift_rise && level != mas_pkg::LVL_OP) begin
         if (phase == mas_pkg::PH_NAME) begin
            next_phase    = mas_pkg::PH_SHOW;
            next_edit_val = stored_val;
         end else if (phase == mas_pkg::PH_SHOW) begin
            next_phase = mas_pkg::PH_EDIT;
         end
      end else if (up_rise && phase == mas_pkg::PH_EDIT) begin
         next_edit_val = (edit_val >= cur_max) ? cur_min
                                               : 16'(edit_val + 16'sd1);
      end
   end

   // Register the sequencer state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level       <= mas_pkg::LVL_OP;
         phase       <= mas_pkg::PH_NAME;
         param_index <= mas_pkg::P_CLEAR;
         edit_val    <= 16'sd0;
         settings    <= '{mas_pkg::AVG_DEFAULT, 1'b0,
                          mas_pkg::HYS_DEFAULT, mas_pkg::HYS_DEFAULT};
         hold_cnt    <= '0;
         hold_done   <= 1'b1;
         keys_q      <= '0;
      end else begin
         level       <= next_level;
         phase       <= next_phase;
         param_index <= next_param;
         edit_val    <= next_edit_val;
         settings    <= next_settings;
         hold_cnt    <= next_hold_cnt;
         hold_done   <= next_hold_done;
         keys_q      <= keys;
      end
   end

   // ----------------------------------------------------------------
   // Display
   // ----------------------------------------------------------------
   always_comb begin
      case (level)
         mas_pkg::LVL_INIT: level_code = mas_pkg::LVL_CODE_INIT;
         mas_pkg::LVL_ADV:  level_code = mas_pkg::LVL_CODE_ADV;
         default:           level_code = mas_pkg::LVL_CODE_OP;
      endcase
   end
   assign value_shown   = (phase != mas_pkg::PH_NAME) && (level != mas_pkg::LVL_OP);
   assign value_blink   = (phase == mas_pkg::PH_EDIT);
   assign display_value = edit_val;
   // Only the hysteresis values carry the measurement decimal point.
   assign display_dp    = (level == mas_pkg::LVL_ADV &&
                           (param_index == mas_pkg::P_HYSTERESIS_OUT_ONE ||
                            param_index == mas_pkg::P_HYSTERESIS_OUT_TWO)) ? ctrl[3:2] : 2'h0;
   assign hys_one_eff   = (settings.hysteresis_out_one == mas_pkg::HYS_DEFAULT)
                          ? mas_pkg::HYS_FLOOR : settings.hysteresis_out_one;
   assign hys_two_eff   = (settings.hysteresis_out_two == mas_pkg::HYS_DEFAULT)
                          ? mas_pkg::HYS_FLOOR : settings.hysteresis_out_two;

   // ----------------------------------------------------------------
   // Process value path
   // ----------------------------------------------------------------
   logic                              avg_valid;
   logic signed [mas_pkg::MEAS_W-1:0] avg_value;
   logic                              next_pv_valid;
   logic signed [mas_pkg::MEAS_W-1:0] next_pv_value;

   mas_avg u_avg (
      .pclk      (pclk),
      .presetn   (presetn),
      .sel       (settings.averaging_count),
      .in_valid  (meas_valid),
      .in_value  (meas_value),
      .out_valid (avg_valid),
      .out_value (avg_value)
   );

   // For analog and remote inputs the event input overrides the mean: hold keeps the last value, zero clears it.
   always_comb begin
      next_pv_valid = avg_valid;
      next_pv_value = pv_value;
      if (event_in && event_ok) begin
         if (settings.event_zero) begin
            next_pv_value = '0;
         end else begin
            next_pv_valid = 1'b0;
         end
      end else if (avg_valid) begin
         next_pv_value = avg_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pv_valid <= 1'b0;
         pv_value <= '0;
      end else begin
         pv_valid <= next_pv_valid;
         pv_value <= next_pv_value;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic        mapped;
   logic [31:0] next_prdata;

   assign mapped  = paddr == mas_pkg::ADDR_CTRL || paddr == mas_pkg::ADDR_STATUS ||
                    paddr == mas_pkg::ADDR_SETTINGS || paddr == mas_pkg::ADDR_HYS ||
                    paddr == mas_pkg::ADDR_PV;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Read data is captured in the setup cycle so it comes from a flop with no
   // wait state; a clear-all beats a same-cycle software write of control.
   always_comb begin
      next_ctrl   = ctrl;
      next_prdata = prdata;
      if (clear_all) begin
         next_ctrl = mas_pkg::CTRL_RESET;
      end else if (psel && penable && pwrite && paddr == mas_pkg::ADDR_CTRL) begin
         next_ctrl = pwdata[mas_pkg::CTRL_W-1:0];
      end
      if (psel && !penable) begin
         case (paddr)
            mas_pkg::ADDR_CTRL:     next_prdata = 32'(ctrl);
            mas_pkg::ADDR_STATUS:   next_prdata = {22'h0, phase, param_index, level_code};
            mas_pkg::ADDR_SETTINGS: next_prdata = {29'h0, settings.event_zero,
                                                   settings.averaging_count};
            mas_pkg::ADDR_HYS:      next_prdata = {2'h0, settings.hysteresis_out_two,
                                                   2'h0, settings.hysteresis_out_one};
            mas_pkg::ADDR_PV:       next_prdata = 32'(pv_value);
            default:                next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= mas_pkg::CTRL_RESET;
         prdata <= 32'h00000000;
      end else begin
         ctrl   <= next_ctrl;
         prdata <= next_prdata;
      end
   end

endmodule

/* design/mas_pkg.sv */
// Shared constants, types and register map of the advanced settings menu.
package mas_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned ENTER_HOLD_S   = 3;
   localparam int unsigned BACK_HOLD_S    = 1;
   localparam int unsigned ENTER_CYCLES   = ENTER_HOLD_S * CLK_HZ;
   localparam int unsigned BACK_CYCLES    = BACK_HOLD_S * CLK_HZ;
   localparam int          HOLD_W         = 30;

   // ----------------------------------------------------------------
   // Register map (byte addresses) and field layout
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS    = 8'h04;
   localparam logic [7:0]  ADDR_SETTINGS  = 8'h08;
   localparam logic [7:0]  ADDR_HYS       = 8'h0C;
   localparam logic [7:0]  ADDR_PV        = 8'h10;
   localparam int          CTRL_W         = 5;
   localparam logic [4:0]  CTRL_RESET     = 5'h00;

   // ----------------------------------------------------------------
   // Codes and value ranges
   // ----------------------------------------------------------------
   localparam logic [3:0]  LVL_CODE_OP    = 4'h0;
   localparam logic [3:0]  LVL_CODE_INIT  = 4'h5;
   localparam logic [3:0]  LVL_CODE_ADV   = 4'hF;
   localparam logic [1:0]  IN_ANALOG      = 2'h0;
   localparam logic [1:0]  IN_REMOTE      = 2'h1;
   localparam logic [2:0]  P_CLEAR        = 3'h0;
   localparam logic [2:0]  P_AVG          = 3'h1;
   localparam logic [2:0]  P_EVENT        = 3'h2;
   localparam logic [2:0]  P_HYSTERESIS_OUT_ONE         = 3'h3;
   localparam logic [2:0]  P_HYSTERESIS_OUT_TWO         = 3'h4;
   localparam logic signed [15:0] PASSWORD   = -16'sd169;
   localparam logic signed [15:0] PASS_MIN   = -16'sd1999;
   localparam logic signed [15:0] HYS_MAX    = 16'sd9999;
   localparam logic signed [15:0] AVG_MAX    = 16'sd3;
   localparam logic signed [15:0] FLAG_MAX   = 16'sd1;
   localparam logic [13:0] HYS_DEFAULT    = 14'h0000;
   localparam logic [13:0] HYS_FLOOR      = 14'h0001;
   localparam logic [1:0]  AVG_DEFAULT    = 2'h0;
   localparam int          MEAS_W         = 20;
   localparam int          AVG_DEPTH      = 8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LVL_OP   = 3'b001,
      LVL_INIT = 3'b010,
      LVL_ADV  = 3'b100
   } mas_level_t;

   typedef enum logic [2:0] {
      PH_NAME  = 3'b001,
      PH_SHOW  = 3'b010,
      PH_EDIT  = 3'b100
   } mas_phase_t;

   typedef struct packed {
      logic mode;
      logic shift;
      logic up;
   } mas_keys_t;

   typedef struct packed {
      logic [1:0]  averaging_count;
      logic        event_zero;
      logic [13:0] hysteresis_out_one;
      logic [13:0] hysteresis_out_two;
   } mas_settings_t;

endpackage

/* design/mas_avg.sv */
// Running mean over the last 1, 2, 4 or 8 measurement samples.
`timescale 1ns/1ps
module mas_avg (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // Selection: 0 off, 1 two, 2 four, 3 eight samples
   input  wire logic [1:0]                  sel,
   // Samples in
   input  wire logic                        in_valid,
   input  wire logic signed [mas_pkg::MEAS_W-1:0] in_value,
   // Mean out
   output logic                             out_valid,
   output logic signed [mas_pkg::MEAS_W-1:0] out_value
);

   localparam int SUM_W = mas_pkg::MEAS_W + 3;

   logic signed [mas_pkg::MEAS_W-1:0] hist      [mas_pkg::AVG_DEPTH];
   logic signed [mas_pkg::MEAS_W-1:0] next_hist [mas_pkg::AVG_DEPTH];
   logic [3:0]                        fill;
   logic [3:0]                        next_fill;
   logic [1:0]                        sel_q;
   logic signed [SUM_W-1:0]           sum;
   logic [3:0]                        need;
   logic                              next_valid;
   logic signed [mas_pkg::MEAS_W-1:0] next_value;

   // History shifts in new samples; a changed count restarts the fill so a
   // mean never mixes in stale samples.
   always_comb begin
      sum        = '0;
      need       = 4'(1) << sel;
      next_fill  = fill;
      next_valid = 1'b0;
      next_value = out_value;
      for (int i = 0; i < mas_pkg::AVG_DEPTH; i++) begin
         next_hist[i] = hist[i];
      end
      if (sel != sel_q) begin
         next_fill = 4'h0;
      end else if (in_valid) begin
         next_hist[0] = in_value;
         for (int i = 1; i < mas_pkg::AVG_DEPTH; i++) begin
            next_hist[i] = hist[i-1];
         end
         if (fill < need) begin
            next_fill = 4'(fill + 4'h1);
         end
         for (int i = 0; i < mas_pkg::AVG_DEPTH; i++) begin
            if (4'(i) < need) begin
               sum = SUM_W'(sum + SUM_W'(next_hist[i]));
            end
         end
         if (next_fill >= need) begin
            next_valid = 1'b1;
            next_value = mas_pkg::MEAS_W'(sum >>> sel);
         end
      end
   end

   // Register the history and the result.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < mas_pkg::AVG_DEPTH; i++) begin
            hist[i] <= '0;
         end
         fill      <= 4'h0;
         sel_q     <= mas_pkg::AVG_DEFAULT;
         out_valid <= 1'b0;
         out_value <= '0;
      end else begin
         hist      <= next_hist;
         fill      <= next_fill;
         sel_q     <= sel;
         out_valid <= next_valid;
         out_value <= next_value;
      end
   end

endmodule

/* verif/mas_key_panel.sv */
// Front-panel keys as a person presses them.
`timescale 1ns/1ps
module mas_key_panel (
   // Clock
   input  wire logic          pclk,
   // Keys toward the menu
   output mas_pkg::mas_keys_t keys
);
   // A released key reads low.
   initial keys = '0;
   // Press key k (2 mode, 1 shift, 0 up) for n cycles; the gap after it makes the next press
   // a fresh edge.
   task automatic press(input int k, input int n);
      @(posedge pclk);
      keys[k] <= 1'b1;
      repeat (n) @(posedge pclk);
      keys[k] <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
endmodule

/* verif/mas_menu_assertions.sv */
// Port checks of the settings menu.
`timescale 1ns/1ps
module mas_menu_assertions #(
   parameter int unsigned ENTER_CYCLES = 40,
   parameter int unsigned BACK_CYCLES  = 20
) (
   // Clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // Watched signals
   input wire mas_pkg::mas_keys_t     keys,
   input wire logic [3:0]             level_code,
   input wire logic [2:0]             param_index,
   input wire logic                   value_blink,
   input wire mas_pkg::mas_settings_t settings,
   input wire logic [13:0]            hys_one_eff,
   input wire logic [13:0]            hys_two_eff
);
   // ------------------------------------------------------------
   // Mode hold counter
   // ------------------------------------------------------------
   localparam logic [3:0] L_OP  = mas_pkg::LVL_CODE_OP;
   localparam logic [3:0] L_INI = mas_pkg::LVL_CODE_INIT;
   localparam logic [3:0] L_ADV = mas_pkg::LVL_CODE_ADV;
   int unsigned mode_cnt;
   int unsigned next_mode_cnt;
   // Counts sampled high cycles; a level change by hold needs enough of them.
   always_comb next_mode_cnt = keys.mode ? mode_cnt + 1 : 0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mode_cnt <= 0;
      else mode_cnt <= next_mode_cnt;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_enter_code: assert property (
      level_code == L_OP ##1 level_code != L_OP |-> level_code == L_INI) else $error("Bad code.");
   chk_enter_hold: assert property (
      level_code == L_OP ##1 level_code == L_INI |-> mode_cnt >= ENTER_CYCLES) else $error("Early.");
   chk_back_adv: assert property (
      level_code == L_ADV ##1 level_code == L_INI |-> mode_cnt >= BACK_CYCLES) else $error("Early.");
   chk_back_init: assert property (
      level_code == L_INI ##1 level_code == L_OP |-> mode_cnt >= BACK_CYCLES) else $error("Early.");
   chk_adv_entry: assert property (
      level_code == L_INI ##1 level_code == L_ADV |-> param_index == 3'h0 && !value_blink)
      else $error("Advanced level opened on wrong item.");
   chk_hys_one: assert property (
      hys_one_eff == (settings.hysteresis_out_one == 14'h0 ? 14'h1 : settings.hysteresis_out_one))
      else $error("Hysteresis one wrong.");
   chk_hys_two: assert property (
      hys_two_eff == (settings.hysteresis_out_two == 14'h0 ? 14'h1 : settings.hysteresis_out_two))
      else $error("Hysteresis two wrong.");
   chk_hys_range: assert property (
      settings.hysteresis_out_one <= 14'd9999 && settings.hysteresis_out_two <= 14'd9999)
      else $error("Hysteresis out of range.");
endmodule
bind mas_menu mas_menu_assertions #(.ENTER_CYCLES(ENTER_CYCLES), .BACK_CYCLES(BACK_CYCLES)) u_chk (
   .pclk, .presetn, .keys, .level_code, .param_index, .value_blink, .settings, .hys_one_eff,
   .hys_two_eff);

/* verif/mas_menu_test.sv */
// Self-checking bench of the settings menu.
`timescale 1ns/1ps
module mas_menu_test;
   // ------------------------------------------------------------
   // Signals, design and key panel
   // ------------------------------------------------------------
   localparam int ENT = 40;
   localparam int BCK = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, event_in, meas_valid, er;
   logic value_shown, value_blink, pv_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] level_code;
   logic [2:0] param_index;
   logic [1:0] display_dp;
   logic signed [15:0] display_value;
   logic [13:0] hys_one_eff, hys_two_eff;
   logic signed [mas_pkg::MEAS_W-1:0] meas_value, pv_value;
   mas_pkg::mas_keys_t keys;
   mas_pkg::mas_settings_t settings;
   int failures, n_compared;
   int ups[5] = '{0, 3, 1, 5, 0};
   int nxt[5] = '{1, 2, 3, 4, 0};
   mas_menu #(.ENTER_CYCLES(ENT), .BACK_CYCLES(BCK)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .keys, .event_in, .meas_valid,
      .meas_value, .level_code, .param_index, .value_shown, .value_blink, .display_value,
      .display_dp, .settings, .hys_one_eff, .hys_two_eff, .pv_valid, .pv_value);
   mas_key_panel u_keys (.pclk, .keys);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task give_verdict;
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, s, x);
      end
   endtask
   // The wait for pready is bounded so a dead slave ends the run instead of hanging it.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         failures++;
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task meas(input int v);
      @(posedge pclk);
      {meas_valid, meas_value} <= {1'b1, v[19:0]};
      @(posedge pclk);
      meas_valid <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, event_in, meas_valid, meas_value} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(hys_one_eff, 14'h1);
      apb(1'b0, 8'h14, 32'h0);
      chk(er, 1'b1);
      // Key protect set too, so that clear-all has something to force off.
      apb(1'b1, mas_pkg::ADDR_CTRL, 32'h18);
      apb(1'b0, mas_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h18);
      u_keys.press(2, ENT + 2);
      chk(level_code, 4'h5);
      u_keys.press(1, 1);
      u_keys.press(1, 1);
      chk(value_blink, 1'b1);
      u_keys.press(2, 1);
      chk(level_code, 4'h5);
      u_keys.press(1, 1);
      u_keys.press(1, 1);
      repeat (11830) u_keys.press(0, 1);
      chk(display_value, 16'shFF57);
      u_keys.press(2, 1);
      chk(level_code, 4'hF);
      // Rows: up presses per item and the item that must follow.
      for (int i = 0; i < 5; i++) begin
         u_keys.press(1, 1);
         chk(value_shown, 1'b1);
         if (i == 0) chk(display_value, 16'h0);
         u_keys.press(1, 1);
         repeat (ups[i]) u_keys.press(0, 1);
         u_keys.press(2, 1);
         chk(param_index, nxt[i]);
         if (nxt[i] == 3) chk(display_dp, 2'h2);
      end
      chk(settings, {2'h3, 1'b1, 14'd5, 14'd0});
      chk(hys_two_eff, 14'h1);
      for (int v = 1; v <= 8; v++) meas(v);
      chk(pv_value, 20'd4);
      event_in <= 1'b1;
      meas(100);
      chk(pv_value, 20'd0);
      u_keys.press(1, 1);
      u_keys.press(1, 1);
      u_keys.press(0, 1);
      u_keys.press(2, 1);
      chk(settings, 31'h0);
      apb(1'b0, mas_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      // Defaults give hold and no averaging: a held event must freeze the last mean.
      event_in <= 1'b0;
      meas(7);
      chk(pv_value, 20'd7);
      event_in <= 1'b1;
      meas(9);
      chk(pv_value, 20'd7);
      apb(1'b1, mas_pkg::ADDR_CTRL, 32'h2);
      u_keys.press(2, 1);
      chk(param_index, 3'h3);
      u_keys.press(2, BCK + 2);
      chk(level_code, 4'h5);
      u_keys.press(2, BCK + 2);
      chk(level_code, 4'h0);
      give_verdict();
   end
endmodule
